// *** rtl/pcs_pkg.sv ***
// Purpose: Shared constants and types for the port chip-select decoder
// Assumes: APB register offsets are byte addresses (word index times four)
// Notes:   Printed offsets are register indices
package pcs_pkg;

  // Register indices as printed, byte address is four times these
  localparam logic [7:0] IDX_POLARITY   = 8'hAE;
  localparam logic [7:0] IDX_CFG01      = 8'hC2;
  localparam logic [7:0] IDX_CFG23      = 8'hC3;
  localparam logic [7:0] IDX_LATCH      = 8'hD8;
  // Base address registers, indices chosen locally
  localparam logic [7:0] IDX_BASE_FIRST = 8'hE0;   // cs0 high, cs0 low, cs1 high ...
  localparam logic [7:0] IDX_PIN_READ   = 8'hE8;   // Pin level readback

  // Reset values
  localparam logic [7:0] RST_LATCH      = 8'hFF;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] POL_MASK       = 8'hF0;   // Reserved low nibble reads zero

  // Field positions inside a config byte for one pin
  localparam int FUN_LSB = 2;
  localparam int CMP_LSB = 0;

  // Pin function modes
  typedef enum logic [1:0] {
    FN_GPIO  = 2'b00,
    FN_READ  = 2'b01,
    FN_WRITE = 2'b10,
    FN_RDWR  = 2'b11
  } pcs_fun_t;

  // Compare-length settings
  typedef enum logic [1:0] {
    CMP_16 = 2'b00,
    CMP_15 = 2'b01,
    CMP_14 = 2'b10,
    CMP_8  = 2'b11
  } pcs_cmp_t;

  // External bus access as seen by the decoder
  typedef struct packed {
    logic [15:0] addr;   // Address bus
    logic        rdN;    // Read strobe, active low
    logic        wrN;    // Write strobe, active low
  } pcs_xbus_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pcs_apb_req_t;

endpackage : pcs_pkg

// *** rtl/pcs_port_decoder.sv ***
// Purpose: Four-pin programmable chip-select port with four plain I/O bits
// Assumes: External bus strobes and pins are synchronous to mclk
// Notes:   APB slave, zero wait states, unmapped reads return zero
`timescale 1ns/10ps
module pcs_port_decoder #(
  parameter int NPIN = 4                     // Number of strobe-capable pins
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // APB slave
  input  wire pcs_pkg::pcs_apb_req_t apbReq,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // External bus being decoded
  input  wire pcs_pkg::pcs_xbus_t xbus,
  // Port pins, quasi-bidirectional
  input  wire logic [7:0]         portIn,
  output logic [7:0]              portOut,
  output logic [7:0]              portOe
);

  // Configuration state
  logic [7:0]  polarity_q;                   // Invert bits in upper nibble
  logic [7:0]  cfg01_q;                      // Pins one and zero
  logic [7:0]  cfg23_q;                      // Pins three and two
  logic [7:0]  latch_q;                      // Port data latch
  logic [15:0] base_q [NPIN];                // Per-pin base address
  logic [7:0]  pinSync_q;                    // Registered pin sample for readback

  // Bus decode
  logic        wrEn;
  logic [9:0]  wIdx;
  logic [7:0]  wByte;

  // Strobe path
  logic [NPIN-1:0] hit;                       // Address and direction match
  logic [NPIN-1:0] isStrobe;                  // Pin is in a strobe mode
  logic [NPIN-1:0] csOut_q;                   // Registered strobe level

  // Pick the four-bit field for one pin from the config bytes
  function automatic logic [3:0] pin_cfg(input logic [7:0] lo, input logic [7:0] hi,
                                         input int p);
    logic [7:0] b;
    b = (p < 2) ? lo : hi;
    pin_cfg = (p % 2 == 1) ? b[7:4] : b[3:0];
  endfunction : pin_cfg

  // Masked address compare
  function automatic logic addr_match(input logic [15:0] a, input logic [15:0] base,
                                      input logic [1:0] cmp);
    logic [15:0] m;
    case (cmp)
      pcs_pkg::CMP_16: m = 16'hFFFF;
      pcs_pkg::CMP_15: m = 16'hFFFE;
      pcs_pkg::CMP_14: m = 16'hFFFC;
      default:         m = 16'hFF00;
    endcase
    addr_match = ((a ^ base) & m) == 16'h0000;
  endfunction : addr_match

  // APB: zero wait states, never an error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn    = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign wIdx    = apbReq.paddr[11:2];
  assign wByte   = apbReq.pwdata[7:0];

  // Polarity register, reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_q <= pcs_pkg::RST_ZERO;
    end else if (wrEn && wIdx == {2'b00, pcs_pkg::IDX_POLARITY}) begin
      polarity_q <= wByte & pcs_pkg::POL_MASK;
    end
  end

  // Configuration bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg01_q <= pcs_pkg::RST_ZERO;
      cfg23_q <= pcs_pkg::RST_ZERO;
    end else if (wrEn && wIdx == {2'b00, pcs_pkg::IDX_CFG01}) begin
      cfg01_q <= wByte;
    end else if (wrEn && wIdx == {2'b00, pcs_pkg::IDX_CFG23}) begin
      cfg23_q <= wByte;
    end
  end

  // Port data latch, all ones after reset like a standard port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= pcs_pkg::RST_LATCH;
    end else if (wrEn && wIdx == {2'b00, pcs_pkg::IDX_LATCH}) begin
      latch_q <= wByte;
    end
  end

  // Base address bytes, high byte at even index, low at odd
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NPIN; p++) begin
        base_q[p] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        if (wrEn && wIdx == 10'(pcs_pkg::IDX_BASE_FIRST + 2 * p)) begin
          base_q[p][15:8] <= wByte;
        end else if (wrEn && wIdx == 10'(pcs_pkg::IDX_BASE_FIRST + 2 * p + 1)) begin
          base_q[p][7:0] <= wByte;
        end
      end
    end
  end

  // Pin readback sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync_q <= pcs_pkg::RST_LATCH;
    end else begin
      pinSync_q <= portIn;
    end
  end

  // Read mux, combinational in the access phase
  always_comb begin
    prdata = 32'h0000_0000;
    if (apbReq.paddr[11:2] == {2'b00, pcs_pkg::IDX_POLARITY}) begin
      prdata[7:0] = polarity_q;
    end else if (apbReq.paddr[11:2] == {2'b00, pcs_pkg::IDX_CFG01}) begin
      prdata[7:0] = cfg01_q;
    end else if (apbReq.paddr[11:2] == {2'b00, pcs_pkg::IDX_CFG23}) begin
      prdata[7:0] = cfg23_q;
    end else if (apbReq.paddr[11:2] == {2'b00, pcs_pkg::IDX_LATCH}) begin
      prdata[7:0] = latch_q;
    end else if (apbReq.paddr[11:2] == {2'b00, pcs_pkg::IDX_PIN_READ}) begin
      prdata[7:0] = pinSync_q;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        if (apbReq.paddr[11:2] == 10'(pcs_pkg::IDX_BASE_FIRST + 2 * p)) begin
          prdata[7:0] = base_q[p][15:8];
        end else if (apbReq.paddr[11:2] == 10'(pcs_pkg::IDX_BASE_FIRST + 2 * p + 1)) begin
          prdata[7:0] = base_q[p][7:0];
        end
      end
    end
  end

  // Per-pin match, gated by the direction the mode allows
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      logic [3:0] c;
      logic       am;
      c  = pin_cfg(cfg01_q, cfg23_q, p);
      am = addr_match(xbus.addr, base_q[p], c[1:0]);
      isStrobe[p] = c[3:2] != pcs_pkg::FN_GPIO;
      case (c[3:2])
        pcs_pkg::FN_READ:  hit[p] = am && !xbus.rdN;
        pcs_pkg::FN_WRITE: hit[p] = am && !xbus.wrN;
        pcs_pkg::FN_RDWR:  hit[p] = am && (!xbus.rdN || !xbus.wrN);
        default:           hit[p] = 1'b0;
      endcase
    end
  end

  // Strobe register, follows the bus strobe one cycle later
  // A registered output keeps glitches from the compare off the pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csOut_q <= '1;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        // Active level while matched, inactive otherwise
        csOut_q[p] <= hit[p] ~^ polarity_q[4 + p];
      end
    end
  end

  // Pin drive: strobe modes drive hard, I/O mode behaves quasi-bidirectional
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      portOut[b] = latch_q[b];
      portOe[b]  = !latch_q[b];                     // Pull low only, weak high outside
    end
    for (int p = 0; p < NPIN; p++) begin
      if (isStrobe[p]) begin
        portOut[p] = csOut_q[p];
        portOe[p]  = 1'b1;
      end
    end
  end

  // Checks
  pol_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    polarity_q[3:0] == 4'h0) else $error("Reserved polarity bits set");

  // A register write in the antecedent cycle would move the level compared against,
  // so the strobe checks require no APB write in that cycle
  rd_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[3:2] == 2'b01 && !xbus.rdN && xbus.wrN && xbus.addr == base_q[0]
     && !wrEn) |=> portOut[0] == polarity_q[4])
    else $error("Read strobe missing on pin zero");

  wr_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[3:2] == 2'b10 && xbus.wrN && !wrEn)
    |=> portOut[0] == !polarity_q[4]) else $error("Write strobe outside write");

  rdwr_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg23_q[7:6] == 2'b11 && !xbus.wrN && xbus.addr == base_q[3]
     && !wrEn) |=> portOut[3] == polarity_q[7])
    else $error("Read/write strobe missing on pin three");

  full_cmp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[3:0] == 4'b1000 && xbus.addr[0] != base_q[0][0]
     && !wrEn) |=> portOut[0] == !polarity_q[4])
    else $error("Full compare ignored bit zero");

  half_cmp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[3:0] == 4'b1001 && !xbus.wrN && xbus.addr[15:1] == base_q[0][15:1]
     && !wrEn) |=> portOut[0] == polarity_q[4])
    else $error("Two-byte window missed");

  quad_cmp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[7:4] == 4'b1010 && !xbus.wrN && xbus.addr[15:2] == base_q[1][15:2]
     && !wrEn) |=> portOut[1] == polarity_q[5])
    else $error("Four-byte window missed");

  page_cmp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg23_q[3:0] == 4'b1011 && !xbus.wrN && xbus.addr[15:8] == base_q[2][15:8]
     && !wrEn) |=> portOut[2] == polarity_q[6])
    else $error("Page window missed");

  gpio_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[3:2] == 2'b00) |-> portOut[0] == latch_q[0] && portOut[7] == latch_q[7])
    else $error("Latch not on I/O pin");

  idle_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (xbus.rdN && xbus.wrN && !wrEn && cfg23_q[7:6] != 2'b00)
    |=> portOut[3] == !polarity_q[7])
    else $error("Idle strobe not inactive");

  // Register file checks, each write lands at its access edge

  // Polarity write keeps only the invert nibble
  pol_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == {2'b00, pcs_pkg::IDX_POLARITY})
    |=> polarity_q == ($past(wByte) & pcs_pkg::POL_MASK))
    else $error("Polarity write lost");

  // Upper config byte takes the whole written byte
  cfg_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == {2'b00, pcs_pkg::IDX_CFG23}) |=> cfg23_q == $past(wByte))
    else $error("Upper config write lost");

  // Lower config byte takes the whole written byte
  cfg_lower_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == {2'b00, pcs_pkg::IDX_CFG01}) |=> cfg01_q == $past(wByte))
    else $error("Lower config write lost");

  // High base byte of pin zero
  base_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == {2'b00, pcs_pkg::IDX_BASE_FIRST}) |=> base_q[0][15:8] == $past(wByte))
    else $error("Base high byte lost");

  // Low base byte of pin zero
  base_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == 10'(pcs_pkg::IDX_BASE_FIRST + 1)) |=> base_q[0][7:0] == $past(wByte))
    else $error("Base low byte lost");

  // Data latch write
  latch_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrEn && wIdx == {2'b00, pcs_pkg::IDX_LATCH}) |=> latch_q == $past(wByte))
    else $error("Latch write lost");

  // Pin drive checks, combinational so they hold in the same cycle

  // Pin two in I/O mode behaves as a quasi-bidirectional bit
  gpio_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg23_q[3:2] == 2'b00) |-> portOut[2] == latch_q[2] && portOe[2] == !latch_q[2])
    else $error("I/O pin two not quasi-bidirectional");

  // Upper four bits are plain I/O whatever the strobe modes
  upper_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    portOut[7:4] == latch_q[7:4] && portOe[7:4] == ~latch_q[7:4])
    else $error("Upper port bits disturbed");

  // A strobe pin is driven hard in both levels
  strobe_oe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg23_q[7:6] != 2'b00) |-> portOe[3])
    else $error("Strobe pin not driven");

  // Timing checks on the strobe pulse

  // Matching write on pin one pulses at the programmed level
  wr_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg01_q[7:6] == 2'b10 && !xbus.wrN && xbus.addr == base_q[1] && !wrEn)
    |=> portOut[1] == polarity_q[5])
    else $error("Write pulse missing on pin one");

  // Pulse ends one cycle after the bus strobe does
  follow_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg23_q[3:2] == 2'b01 && !xbus.rdN && xbus.addr == base_q[2] && !wrEn
     ##1 xbus.rdN && xbus.wrN && !wrEn) |=> portOut[2] == !polarity_q[6])
    else $error("Strobe outlasts bus strobe");

  // Main scenarios
  wr_pulse_c: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg01_q[3:2] == 2'b10 && hit[0] ##1 !hit[0]);
  rd_pulse_c: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg23_q[7:6] == 2'b01 && hit[3]);
  high_pol_c: cover property (@(posedge mclk) disable iff (!rst_n)
    polarity_q[4] && hit[0]);
  rdwr_hit_c: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg23_q[7:6] == 2'b11 && hit[3]);
  page_hit_c: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg23_q[3:0] == 4'b1011 && hit[2]);

endmodule : pcs_port_decoder

// *** dv/pcs_periph_model.sv ***
// Purpose: Far side of the strobe port, peripherals and pin wiring
// Assumes: Quasi-bidirectional pins with a weak pull-up
// Notes:   Resolves each pin level and counts strobe cycles seen
`timescale 1ns/10ps
module pcs_periph_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Pin drivers from the port
  input  wire logic [7:0] portOut,
  input  wire logic [7:0] portOe,
  // Resolved pin levels
  output logic      [7:0] portIn,
  output logic      [7:0] lowCount
);
  // Undriven pins float up, never to a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      portIn[i] = portOe[i] ? portOut[i] : 1'b1;
    end
  end

  // Low-level cycles on the strobe pins, a peripheral's view of selects
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowCount <= 8'h00;
    end else if (portIn[3:0] != 4'hF) begin
      lowCount <= lowCount + 8'h01;
    end
  end
endmodule : pcs_periph_model

// *** dv/port_chip_select_decoder_tb.sv ***
// Purpose: Self-checking bench for the chip-select port decoder
// Assumes: Zero-wait APB slave, strobe output one cycle behind bus
// Notes:   Random bases and addresses from a fixed xorshift seed
`timescale 1ns/10ps
module port_chip_select_decoder_tb;
  logic                  mclk;      // 250 MHz clock
  logic                  rst_n;     // Async reset
  pcs_pkg::pcs_apb_req_t req;       // APB request
  pcs_pkg::pcs_xbus_t    xbus;      // External bus
  logic [31:0]           prdata;    // APB read data
  logic                  pready;    // APB ready
  logic [7:0]            portIn;    // Resolved pins
  logic [7:0]            portOut;   // Pin values
  logic [7:0]            portOe;    // Pin enables
  logic [31:0]           seed;      // Xorshift state
  logic [7:0]            rdat;      // Last read byte
  int                    failCount; // Mismatches
  int                    checked;   // Comparisons
  int                    cycles;    // Timeout counter

  // Design under test
  pcs_port_decoder dut (.mclk(mclk), .rst_n(rst_n), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(), .xbus(xbus), .portIn(portIn), .portOut(portOut),
    .portOe(portOe));

  // Peripherals and pin pull-ups
  pcs_periph_model peer (.mclk(mclk), .rst_n(rst_n), .portOut(portOut), .portOe(portOe),
    .portIn(portIn), .lowCount());

  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard, well above the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failCount = failCount + 1;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected pin level for one access, from mode, length and polarity
  function automatic logic exp_pin(logic [15:0] base, logic [15:0] a, logic [1:0] fn,
                                   logic [1:0] cmp, logic rd, logic pol);
    logic [15:0] m;
    m = (cmp == 2'h0) ? 16'hFFFF : (cmp == 2'h1) ? 16'hFFFE :
        (cmp == 2'h2) ? 16'hFFFC : 16'hFF00;
    return (((a & m) == (base & m)) && (rd ? fn[0] : fn[1])) ? pol : ~pol;
  endfunction : exp_pin

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {2'b00, idx, 2'b00};
    req.pwdata  <= {24'h0, wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata[7:0];
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // External access on pin p, then the idle cycle after it
  task automatic xacc(input int p, input logic [15:0] a, input logic rd, input logic e,
                      input logic il);
    @(posedge mclk);
    xbus <= '{a, ~rd, rd};
    @(posedge mclk);
    #1 check(portOut[p], e);
    check(portOe[p], 1'b1);
    @(posedge mclk);
    xbus <= '{~a, 1'b1, 1'b1};
    @(posedge mclk);
    #1 check(portOut[p], il);
  endtask : xacc

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    logic [15:0] base;
    logic [15:0] a;
    logic [7:0]  pol;
    logic [7:0]  cfg;
    logic        rd;
    req = '0;
    xbus = '{16'h0000, 1'b1, 1'b1};
    rst_n = 1'b0;
    seed = 32'd10;
    failCount = 0;
    checked = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, pcs_pkg::IDX_LATCH, 8'h00);
    check(rdat, pcs_pkg::RST_LATCH);
    check({portOut, portOe}, 16'hFF00);
    apb(1'b1, pcs_pkg::IDX_POLARITY, 8'hFF);
    apb(1'b0, pcs_pkg::IDX_POLARITY, 8'h00);
    check(rdat, pcs_pkg::POL_MASK);
    apb(1'b0, 8'h10, 8'h00);
    check(rdat, 32'h0);
    // Plain port bits: bus traffic must not disturb the latch on the pins
    apb(1'b1, pcs_pkg::IDX_LATCH, 8'hA5);
    xbus <= '{16'h0000, 1'b0, 1'b1};
    apb(1'b0, pcs_pkg::IDX_PIN_READ, 8'h00);
    check(rdat, 8'hA5);
    check({portOut, portOe}, 16'hA55A);
    xbus <= '{16'h0000, 1'b1, 1'b1};
    for (int p = 0; p < 4; p++) begin
      for (int fn = 1; fn < 4; fn++) begin
        for (int cmp = 0; cmp < 4; cmp++) begin
          base = 16'(rnd());
          pol = {4'(rnd()), 4'h0};
          cfg = 8'({fn[1:0], cmp[1:0]}) << (4 * (p % 2));
          apb(1'b1, (p < 2) ? pcs_pkg::IDX_CFG23 : pcs_pkg::IDX_CFG01, 8'h00);
          apb(1'b1, (p < 2) ? pcs_pkg::IDX_CFG01 : pcs_pkg::IDX_CFG23, cfg);
          apb(1'b0, (p < 2) ? pcs_pkg::IDX_CFG01 : pcs_pkg::IDX_CFG23, 8'h00);
          check(rdat, cfg);
          apb(1'b1, pcs_pkg::IDX_BASE_FIRST + 8'(2 * p), base[15:8]);
          apb(1'b1, pcs_pkg::IDX_BASE_FIRST + 8'(2 * p + 1), base[7:0]);
          apb(1'b1, pcs_pkg::IDX_POLARITY, pol);
          for (int k = 0; k < 4; k++) begin
            a = 16'(rnd());
            rd = a[15];
            if (k < 3) a = base ^ (a & ~((cmp == 3) ? 16'hFF00 : 16'hFFFF << cmp));
            xacc(p, a, rd, exp_pin(base, a, fn[1:0], cmp[1:0], rd, pol[4 + p]),
                 ~pol[4 + p]);
          end
        end
      end
    end
    end_of_test();
  end
endmodule : port_chip_select_decoder_tb
